// [hdl/pspk_defines.vh]
// Purpose: Constants for the port status image packer
// Assumes: Byte-wide register port, 4-bit address
// Notes:   Byte 0 holds ports 0-7, byte 1 holds ports 8-15
`ifndef PSPK_DEFINES_VH
`define PSPK_DEFINES_VH

// Register addresses
`define PSPK_ADDR_DIAG_EN_LO     4'h0
`define PSPK_ADDR_DIAG_EN_HI     4'h1
`define PSPK_ADDR_CTRL           4'h2
`define PSPK_ADDR_COMM_LO        4'h3
`define PSPK_ADDR_COMM_HI        4'h4
`define PSPK_ADDR_PERR_LO        4'h5
`define PSPK_ADDR_PERR_HI        4'h6
`define PSPK_ADDR_SSHORT_LO      4'h7
`define PSPK_ADDR_SSHORT_HI      4'h8
`define PSPK_ADDR_PDV_LO         4'h9
`define PSPK_ADDR_PDV_HI         4'hA
`define PSPK_ADDR_STATION        4'hB

// Control register fields
`define PSPK_CTRL_DIAG_SW_BIT    0

// Reset values
`define PSPK_RST_DIAG_EN         16'h0000
`define PSPK_RST_CTRL            8'h00
`define PSPK_RST_IMAGE           16'h0000
`define PSPK_RST_BYTE            8'h00
`define PSPK_ALL_PORTS           16'hFFFF

// Station diagnostics byte fields
`define PSPK_ST_SENS_LOW_BIT     0
`define PSPK_ST_ACT_LOW_BIT      1
`define PSPK_ST_ACT_MISS_BIT     2
`define PSPK_ST_EXT_ERR_BIT      3
`define PSPK_ST_SENS_SHORT_BIT   4
`define PSPK_ST_ACT_SHORT_BIT    5
`define PSPK_ST_ACT_WARN_BIT     6
`define PSPK_ST_IOL_SHORT_BIT    7

`endif

// [hdl/pspk_sync.v]
// Purpose: Two-stage synchroniser for a bundle of level inputs
// Assumes: Inputs are slow levels; per-bit skew of one cycle is harmless
// Notes:   Both stages freeze while the clock enable is low
`timescale 1ns/100ps
module pspk_sync #(
   parameter WIDTH = 8
) (
   input  wire             clk_i,
   input  wire             rst_i,
   input  wire             ce_i,
   input  wire [WIDTH-1:0] async_i,
   output wire [WIDTH-1:0] sync_o
);

   reg [WIDTH-1:0] meta_q;
   reg [WIDTH-1:0] sync_q;

   // First stage is read by the second stage only
   always @(posedge clk_i) begin
      if (rst_i) begin
         meta_q <= {WIDTH{1'b0}};
         sync_q <= {WIDTH{1'b0}};
      end else if (ce_i) begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;

endmodule // pspk_sync

// [hdl/pspk_packer.v]
// Purpose: Per-port status and control images for a 16-port IO-Link module
// Assumes: Status inputs arrive from pins, so they are synchronised first
// Notes:   Images are rebuilt every enabled cycle; nothing is latched
//          Map 0x0/0x1 diag mask lo/hi, 0x2 control (bit0 switch), read-write
//          Map 0x3/0x4 comm, 0x5/0x6 periph error, 0x7/0x8 supply short
//          Map 0x9/0xA process data valid, 0xB station byte, all read-only
//          Reads of 0xC-0xF give zero; writes to read-only bytes are dropped
//
// Function
// - Diagnostics-switch on: suppress all port diagnostics, re-enable per mask bit.
// - One communication-established bit per port, ports 0-7 byte 0, 8-15 byte 1.
// - Per-port peripheral-error bit in the same two-byte layout.
// - Per-port sensor-supply short-circuit bit in the same two-byte layout.
// - Per-port process-data-valid bit: 1 valid, 0 not valid.
// - Station diagnostics byte: supplies low/missing, external error, shorts, warning.
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
`include "pspk_defines.vh"
module pspk_packer #(
   parameter PORTS = 16
) (
   input  wire             CORE_CLK_I,
   input  wire             RST_I,
   input  wire             CE_I,
   // Register port
   input  wire [3:0]       ADDR_I,
   input  wire [7:0]       WDATA_I,
   input  wire             WR_I,
   input  wire             RD_I,
   output wire [7:0]       RDATA_O,
   // Per-port status from the port controllers
   input  wire [PORTS-1:0] COMM_OK_I,
   input  wire [PORTS-1:0] PERIPH_ERR_I,
   input  wire [PORTS-1:0] SENS_SHORT_I,
   input  wire [PORTS-1:0] PROCESS_DATA_VALID_FLAGS_I,
   // Station conditions
   input  wire             SENS_SUPPLY_LOW_I,
   input  wire             ACT_SUPPLY_LOW_I,
   input  wire             ACT_SUPPLY_MISSING_I,
   input  wire             EXT_ERR_I,
   input  wire             ACT_SHORT_I,
   input  wire             ACT_WARN_I,
   input  wire             IOL_SHORT_I,
   // Images toward the port logic and the fieldbus side
   output wire [PORTS-1:0] DIAG_EN_O,
   output wire             DIAG_SW_O,
   output wire [PORTS-1:0] COMM_IMG_O,
   output wire [PORTS-1:0] PERR_IMG_O,
   output wire [PORTS-1:0] SSHORT_IMG_O,
   output wire [PORTS-1:0] PDV_IMG_O,
   output wire [7:0]       STATION_DIAG_O
);

   localparam SYNC_W = 4 * PORTS + 7;

   // Group offsets inside the synchroniser bundle, matching raw_in packing
   localparam OFS_COMM   = 0;
   localparam OFS_PERR   = PORTS;
   localparam OFS_SSHORT = 2 * PORTS;
   localparam OFS_PDV    = 3 * PORTS;
   localparam OFS_STAT   = 4 * PORTS;

   // Picks byte 0 or byte 1 of a 16-bit image as given; unused ports are zeroed by to_img, not here
   function [7:0] img_byte;
      input [15:0] img;
      input        hi;
      begin
         img_byte = hi ? img[15:8] : img[7:0];
      end
   endfunction

   // Widens a port vector to the 16-bit image, unused ports zero
   function [15:0] to_img;
      input [PORTS-1:0] v;
      reg   [15:0]      t;
      integer           k;
      begin
         t = 16'h0000;
         for (k = 0; k < PORTS; k = k + 1) begin
            t[k] = v[k];
         end
         to_img = t;
      end
   endfunction

   wire [SYNC_W-1:0] raw_in;
   wire [SYNC_W-1:0] syn_in;

   wire [PORTS-1:0] comm_s;
   wire [PORTS-1:0] perr_s;
   wire [PORTS-1:0] sshort_s;
   wire [PORTS-1:0] pdv_s;
   wire             sens_low_s;
   wire             act_low_s;
   wire             act_miss_s;
   wire             ext_err_s;
   wire             act_short_s;
   wire             act_warn_s;
   wire             iol_short_s;

   reg  [15:0] diag_mask_q;
   reg  [7:0]  ctrl_q;
   reg  [15:0] diag_en_q;
   reg  [15:0] diag_en_d;
   reg  [15:0] comm_q;
   reg  [15:0] perr_q;
   reg  [15:0] sshort_q;
   reg  [15:0] pdv_q;
   reg  [7:0]  station_q;
   reg  [7:0]  station_d;
   reg  [7:0]  rdata_q;
   reg  [7:0]  rdata_d;

   wire        diag_sw;
   wire        wr_en;

   assign raw_in = {IOL_SHORT_I,
                    ACT_WARN_I,
                    ACT_SHORT_I,
                    EXT_ERR_I,
                    ACT_SUPPLY_MISSING_I,
                    ACT_SUPPLY_LOW_I,
                    SENS_SUPPLY_LOW_I,
                    PROCESS_DATA_VALID_FLAGS_I,
                    SENS_SHORT_I,
                    PERIPH_ERR_I,
                    COMM_OK_I};

   // Pins come from outside this clock, so all of them pass two stages
   pspk_sync #(
      .WIDTH (SYNC_W)
   ) u_sync (
      .clk_i   (CORE_CLK_I),
      .rst_i   (RST_I),
      .ce_i    (CE_I),
      .async_i (raw_in),
      .sync_o  (syn_in)
   );

   assign comm_s      = syn_in[OFS_COMM +: PORTS];
   assign perr_s      = syn_in[OFS_PERR +: PORTS];
   assign sshort_s    = syn_in[OFS_SSHORT +: PORTS];
   assign pdv_s       = syn_in[OFS_PDV +: PORTS];
   assign sens_low_s  = syn_in[OFS_STAT];
   assign act_low_s   = syn_in[OFS_STAT+1];
   assign act_miss_s  = syn_in[OFS_STAT+2];
   assign ext_err_s   = syn_in[OFS_STAT+3];
   assign act_short_s = syn_in[OFS_STAT+4];
   assign act_warn_s  = syn_in[OFS_STAT+5];
   assign iol_short_s = syn_in[OFS_STAT+6];

   assign diag_sw = ctrl_q[`PSPK_CTRL_DIAG_SW_BIT];

   // A strobe seen while the enable is low is lost, not deferred
   assign wr_en = CE_I & WR_I;

   // Software-written mask and control
   always @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         diag_mask_q <= `PSPK_RST_DIAG_EN;
         ctrl_q      <= `PSPK_RST_CTRL;
      end else if (wr_en) begin
         case (ADDR_I)
            `PSPK_ADDR_DIAG_EN_LO: begin
               diag_mask_q[7:0] <= WDATA_I;
            end
            `PSPK_ADDR_DIAG_EN_HI: begin
               diag_mask_q[15:8] <= WDATA_I;
            end
            `PSPK_ADDR_CTRL: begin
               // Only the switch bit exists; the rest stays zero
               ctrl_q <= {7'h00, WDATA_I[`PSPK_CTRL_DIAG_SW_BIT]};
            end
            default: begin
               // Image registers are read-only; writes are dropped
               ctrl_q <= ctrl_q;
            end
         endcase
      end
   end

   always @* begin
      if (diag_sw) begin
         diag_en_d = diag_mask_q & to_img({PORTS{1'b1}});
      end else begin
         diag_en_d = to_img({PORTS{1'b1}});
      end
   end

   always @* begin
      station_d = `PSPK_RST_BYTE;
      station_d[`PSPK_ST_SENS_LOW_BIT]   = sens_low_s;
      station_d[`PSPK_ST_ACT_LOW_BIT]    = act_low_s;
      station_d[`PSPK_ST_ACT_MISS_BIT]   = act_miss_s;
      station_d[`PSPK_ST_EXT_ERR_BIT]    = ext_err_s;
      // Any port short sets the station sensor-voltage short bit; it has no station input of its own
      station_d[`PSPK_ST_SENS_SHORT_BIT] = |sshort_s;
      station_d[`PSPK_ST_ACT_SHORT_BIT]  = act_short_s;
      station_d[`PSPK_ST_ACT_WARN_BIT]   = act_warn_s;
      station_d[`PSPK_ST_IOL_SHORT_BIT]  = iol_short_s;
   end

   always @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         diag_en_q <= `PSPK_ALL_PORTS;
         comm_q    <= `PSPK_RST_IMAGE;
         perr_q    <= `PSPK_RST_IMAGE;
         sshort_q  <= `PSPK_RST_IMAGE;
         pdv_q     <= `PSPK_RST_IMAGE;
         station_q <= `PSPK_RST_BYTE;
      end else if (CE_I) begin
         diag_en_q <= diag_en_d;
         comm_q    <= to_img(comm_s);
         perr_q    <= to_img(perr_s);
         sshort_q  <= to_img(sshort_s);
         pdv_q     <= to_img(pdv_s);
         station_q <= station_d;
      end
   end

   always @* begin
      case (ADDR_I)
         `PSPK_ADDR_DIAG_EN_LO: rdata_d = img_byte(diag_mask_q, 1'b0);
         `PSPK_ADDR_DIAG_EN_HI: rdata_d = img_byte(diag_mask_q, 1'b1);
         `PSPK_ADDR_CTRL:       rdata_d = ctrl_q;
         `PSPK_ADDR_COMM_LO:    rdata_d = img_byte(comm_q, 1'b0);
         `PSPK_ADDR_COMM_HI:    rdata_d = img_byte(comm_q, 1'b1);
         `PSPK_ADDR_PERR_LO:    rdata_d = img_byte(perr_q, 1'b0);
         `PSPK_ADDR_PERR_HI:    rdata_d = img_byte(perr_q, 1'b1);
         `PSPK_ADDR_SSHORT_LO:  rdata_d = img_byte(sshort_q, 1'b0);
         `PSPK_ADDR_SSHORT_HI:  rdata_d = img_byte(sshort_q, 1'b1);
         `PSPK_ADDR_PDV_LO:     rdata_d = img_byte(pdv_q, 1'b0);
         `PSPK_ADDR_PDV_HI:     rdata_d = img_byte(pdv_q, 1'b1);
         `PSPK_ADDR_STATION:    rdata_d = station_q;
         default:               rdata_d = `PSPK_RST_BYTE;
      endcase
   end

   // Read data valid in the cycle after the strobe, zero after the next enabled edge without it; held while the enable is low
   always @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         rdata_q <= `PSPK_RST_BYTE;
      end else if (CE_I) begin
         if (RD_I) begin
            rdata_q <= rdata_d;
         end else begin
            rdata_q <= `PSPK_RST_BYTE;
         end
      end
   end

   assign RDATA_O        = rdata_q;
   assign DIAG_EN_O      = diag_en_q[PORTS-1:0];
   assign DIAG_SW_O      = diag_sw;
   assign COMM_IMG_O     = comm_q[PORTS-1:0];
   assign PERR_IMG_O     = perr_q[PORTS-1:0];
   assign SSHORT_IMG_O   = sshort_q[PORTS-1:0];
   assign PDV_IMG_O      = pdv_q[PORTS-1:0];
   assign STATION_DIAG_O = station_q;

endmodule // pspk_packer

// [testbench/pspk_monitor.sv]
// Purpose: Port-level checker for the status image packer
// Assumes: CE_I drops only while inputs are steady; images lag three edges
// Notes:   Reads are checked on the comm low byte only
`timescale 1ns/100ps
module pspk_monitor #(
   parameter PORTS = 16
) (
   input wire             CORE_CLK_I,
   input wire             RST_I,
   input wire             RD_I,
   input wire [3:0]       ADDR_I,
   input wire [7:0]       RDATA_O,
   input wire [PORTS-1:0] COMM_OK_I,
   input wire [PORTS-1:0] PERIPH_ERR_I,
   input wire [PORTS-1:0] SENS_SHORT_I,
   input wire [PORTS-1:0] PROCESS_DATA_VALID_FLAGS_I,
   input wire             SENS_SUPPLY_LOW_I,
   input wire             ACT_SUPPLY_LOW_I,
   input wire             ACT_SUPPLY_MISSING_I,
   input wire             EXT_ERR_I,
   input wire             ACT_SHORT_I,
   input wire             ACT_WARN_I,
   input wire             IOL_SHORT_I,
   input wire [PORTS-1:0] DIAG_EN_O,
   input wire             DIAG_SW_O,
   input wire [PORTS-1:0] COMM_IMG_O,
   input wire [PORTS-1:0] PERR_IMG_O,
   input wire [PORTS-1:0] SSHORT_IMG_O,
   input wire [PORTS-1:0] PDV_IMG_O,
   input wire [7:0]       STATION_DIAG_O
);
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (RST_I);
   chk_diag_all_on: assert property ($past(DIAG_SW_O) == 1'b0 |-> &DIAG_EN_O)
      else $error("diag enable not all ports");
   chk_comm_image: assert property (COMM_IMG_O == $past(COMM_OK_I, 3))
      else $error("comm image wrong");
   chk_perr_image: assert property (PERR_IMG_O == $past(PERIPH_ERR_I, 3))
      else $error("periph error image wrong");
   chk_short_image: assert property (SSHORT_IMG_O == $past(SENS_SHORT_I, 3))
      else $error("sensor short image wrong");
   chk_pdv_image: assert property (PDV_IMG_O == $past(PROCESS_DATA_VALID_FLAGS_I, 3))
      else $error("process data valid image wrong");
   chk_station_byte: assert property (STATION_DIAG_O == $past({IOL_SHORT_I, ACT_WARN_I,
      ACT_SHORT_I, |SENS_SHORT_I, EXT_ERR_I, ACT_SUPPLY_MISSING_I, ACT_SUPPLY_LOW_I,
      SENS_SUPPLY_LOW_I}, 3)) else $error("station byte wrong");
   chk_rdata_idle: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
      else $error("read data not zero when idle");
   chk_comm_read: assert property ($past(RD_I) && $past(ADDR_I) == 4'h3
      |-> RDATA_O == $past(COMM_IMG_O[7:0])) else $error("comm low read wrong");
   cover property (RD_I && ADDR_I == 4'hB);
   cover property ($rose(DIAG_SW_O));
   cover property (|SSHORT_IMG_O);
endmodule // pspk_monitor

// [testbench/pspk_port_model.sv]
// Purpose: Port controller side driving status levels
// Assumes: Bench states the wanted conditions
// Notes:   Plain levels, launched just after the clock edge
`timescale 1ns/100ps
module pspk_port_model (
   input  wire        clk_i,
   input  wire [63:0] cond_i,
   input  wire [6:0]  stat_i,
   output reg  [63:0] port_o = 64'h0000_0000_0000_0000,
   output reg  [6:0]  stat_o = 7'h00
);
   always @(posedge clk_i) begin
      port_o <= cond_i;
      stat_o <= stat_i;
   end
endmodule // pspk_port_model

// [testbench/port_status_image_packer_bench.sv]
// Purpose: Self-checking bench for the status image packer
// Assumes: CE_I high except one short frozen-write test; reset six cycles
// Notes:   Register port driven by tasks
`timescale 1ns/100ps
`include "pspk_defines.vh"
module port_status_image_packer_bench;
   reg         CORE_CLK_I = 1'b0;
   reg         RST_I = 1'b1;
   reg         CE_I = 1'b1;
   reg  [3:0]  ADDR_I = 4'h0;
   reg  [7:0]  WDATA_I = 8'h00;
   reg         WR_I = 1'b0;
   reg         RD_I = 1'b0;
   wire [7:0]  RDATA_O;
   wire [15:0] COMM_OK_I, PERIPH_ERR_I, SENS_SHORT_I, PROCESS_DATA_VALID_FLAGS_I;
   wire        SENS_SUPPLY_LOW_I, ACT_SUPPLY_LOW_I, ACT_SUPPLY_MISSING_I, EXT_ERR_I;
   wire        ACT_SHORT_I, ACT_WARN_I, IOL_SHORT_I, DIAG_SW_O;
   wire [15:0] DIAG_EN_O, COMM_IMG_O, PERR_IMG_O, SSHORT_IMG_O, PDV_IMG_O;
   wire [7:0]  STATION_DIAG_O;
   wire [63:0] imgs = {PDV_IMG_O, SSHORT_IMG_O, PERR_IMG_O, COMM_IMG_O};
   reg  [63:0] cond = 64'h0000_0000_0000_0000;
   reg  [6:0]  stat = 7'h00;
   reg  [7:0]  rv;
   reg  [15:0] pat;
   integer     n_errors = 0;
   integer     total_checks = 0;
   integer     cycles = 0;
   integer     k;
   pspk_packer #(.PORTS(16)) i_pspk_packer (
      .CORE_CLK_I                 (CORE_CLK_I),
      .RST_I                      (RST_I),
      .CE_I                       (CE_I),
      .ADDR_I                     (ADDR_I),
      .WDATA_I                    (WDATA_I),
      .WR_I                       (WR_I),
      .RD_I                       (RD_I),
      .RDATA_O                    (RDATA_O),
      .COMM_OK_I                  (COMM_OK_I),
      .PERIPH_ERR_I               (PERIPH_ERR_I),
      .SENS_SHORT_I               (SENS_SHORT_I),
      .PROCESS_DATA_VALID_FLAGS_I (PROCESS_DATA_VALID_FLAGS_I),
      .SENS_SUPPLY_LOW_I          (SENS_SUPPLY_LOW_I),
      .ACT_SUPPLY_LOW_I           (ACT_SUPPLY_LOW_I),
      .ACT_SUPPLY_MISSING_I       (ACT_SUPPLY_MISSING_I),
      .EXT_ERR_I                  (EXT_ERR_I),
      .ACT_SHORT_I                (ACT_SHORT_I),
      .ACT_WARN_I                 (ACT_WARN_I),
      .IOL_SHORT_I                (IOL_SHORT_I),
      .DIAG_EN_O                  (DIAG_EN_O),
      .DIAG_SW_O                  (DIAG_SW_O),
      .COMM_IMG_O                 (COMM_IMG_O),
      .PERR_IMG_O                 (PERR_IMG_O),
      .SSHORT_IMG_O               (SSHORT_IMG_O),
      .PDV_IMG_O                  (PDV_IMG_O),
      .STATION_DIAG_O             (STATION_DIAG_O)
   );
   pspk_port_model i_pspk_port_model (.clk_i(CORE_CLK_I), .cond_i(cond), .stat_i(stat),
      .port_o({PROCESS_DATA_VALID_FLAGS_I, SENS_SHORT_I, PERIPH_ERR_I, COMM_OK_I}),
      .stat_o({IOL_SHORT_I, ACT_WARN_I, ACT_SHORT_I, EXT_ERR_I, ACT_SUPPLY_MISSING_I,
      ACT_SUPPLY_LOW_I, SENS_SUPPLY_LOW_I}));
   initial begin
      forever #5 CORE_CLK_I = ~CORE_CLK_I;
   end
   task close_out;
      begin
         $display("checks %0d mismatches %0d", total_checks, n_errors);
         if (n_errors == 0 && total_checks > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   task chk(input string nm, input [15:0] exp, input [15:0] got);
      begin
         total_checks = total_checks + 1;
         if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("[FAIL] %0s expected %h seen %h", nm, exp, got);
         end
      end
   endtask
   task wr(input [3:0] a, input [7:0] d);
      begin
         @(posedge CORE_CLK_I);
         WR_I <= 1'b1;
         ADDR_I <= a;
         WDATA_I <= d;
         @(posedge CORE_CLK_I);
         WR_I <= 1'b0;
      end
   endtask
   // Read data stands only in the cycle after the strobe
   task rd(input [3:0] a);
      begin
         @(posedge CORE_CLK_I);
         RD_I <= 1'b1;
         ADDR_I <= a;
         @(posedge CORE_CLK_I);
         RD_I <= 1'b0;
         #1 rv = RDATA_O;
      end
   endtask
   // Bounded run; the tests need well under a thousand cycles
   always @(posedge CORE_CLK_I) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_errors = n_errors + 1;
         close_out;
      end
   end
   initial begin
      repeat (6) @(posedge CORE_CLK_I);
      RST_I <= 1'b0;
      rd(`PSPK_ADDR_CTRL);
      chk("ctrl", 16'h0000, {8'h00, rv});
      #1 chk("diag_en", 16'hFFFF, DIAG_EN_O);
      $display("test reset done");
      wr(`PSPK_ADDR_DIAG_EN_LO, 8'hA5);
      wr(`PSPK_ADDR_DIAG_EN_HI, 8'h3C);
      wr(`PSPK_ADDR_CTRL, 8'hFF);
      repeat (2) @(posedge CORE_CLK_I);
      #1 chk("diag_en", 16'h3CA5, DIAG_EN_O);
      rd(`PSPK_ADDR_CTRL);
      chk("ctrl", 16'h0001, {8'h00, rv});
      rd(`PSPK_ADDR_DIAG_EN_HI);
      chk("mask_hi", 16'h003C, {8'h00, rv});
      wr(`PSPK_ADDR_CTRL, 8'h00);
      repeat (2) @(posedge CORE_CLK_I);
      #1 chk("diag_en", 16'hFFFF, DIAG_EN_O);
      $display("test diag switch done");
      // A write strobe while the enable is low must not land
      @(posedge CORE_CLK_I);
      CE_I <= 1'b0;
      wr(`PSPK_ADDR_DIAG_EN_LO, 8'h00);
      CE_I <= 1'b1;
      rd(`PSPK_ADDR_DIAG_EN_LO);
      chk("mask_lo_ce", 16'h00A5, {8'h00, rv});
      $display("test clock enable done");
      for (k = 0; k < 4; k = k + 1) begin
         pat = 16'h8001 ^ (16'h0F30 << k);
         cond <= {48'h0000_0000_0000, pat} << (16 * k);
         repeat (4) @(posedge CORE_CLK_I);
         #1 chk("image", pat, imgs[16*k +: 16]);
         rd(4'(3 + 2 * k));
         chk("image_lo", {8'h00, pat[7:0]}, {8'h00, rv});
         rd(4'(4 + 2 * k));
         chk("image_hi", {8'h00, pat[15:8]}, {8'h00, rv});
      end
      cond <= 64'h0000_0000_0000_0000;
      repeat (4) @(posedge CORE_CLK_I);
      #1 chk("images", 16'h0000, imgs[15:0] | imgs[31:16] | imgs[47:32] | imgs[63:48]);
      $display("test images done");
      for (k = 0; k < 8; k = k + 1) begin
         cond <= (k == 4) ? 64'h0000_1000_0000_0000 : 64'h0000_0000_0000_0000;
         stat <= (k == 4) ? 7'h00 : 7'h01 << (k < 4 ? k : k - 1);
         repeat (4) @(posedge CORE_CLK_I);
         rd(`PSPK_ADDR_STATION);
         chk("station", 16'h0001 << k, {8'h00, rv});
      end
      stat <= 7'h00;
      cond <= 64'h0000_0000_0000_0000;
      $display("test station done");
      wr(`PSPK_ADDR_COMM_LO, 8'hFF);
      wr(`PSPK_ADDR_STATION, 8'hFF);
      repeat (4) @(posedge CORE_CLK_I);
      rd(`PSPK_ADDR_COMM_LO);
      chk("comm_lo", 16'h0000, {8'h00, rv});
      rd(`PSPK_ADDR_DIAG_EN_LO);
      chk("mask_lo", 16'h00A5, {8'h00, rv});
      rd(`PSPK_ADDR_STATION);
      chk("station", 16'h0000, {8'h00, rv});
      rd(4'hC);
      chk("unmapped", 16'h0000, {8'h00, rv});
      $display("test refused done");
      close_out;
   end
endmodule // port_status_image_packer_bench
bind pspk_packer pspk_monitor #(.PORTS(PORTS)) i_pspk_monitor (
   .CORE_CLK_I                 (CORE_CLK_I),
   .RST_I                      (RST_I),
   .RD_I                       (RD_I),
   .ADDR_I                     (ADDR_I),
   .RDATA_O                    (RDATA_O),
   .COMM_OK_I                  (COMM_OK_I),
   .PERIPH_ERR_I               (PERIPH_ERR_I),
   .SENS_SHORT_I               (SENS_SHORT_I),
   .PROCESS_DATA_VALID_FLAGS_I (PROCESS_DATA_VALID_FLAGS_I),
   .SENS_SUPPLY_LOW_I          (SENS_SUPPLY_LOW_I),
   .ACT_SUPPLY_LOW_I           (ACT_SUPPLY_LOW_I),
   .ACT_SUPPLY_MISSING_I       (ACT_SUPPLY_MISSING_I),
   .EXT_ERR_I                  (EXT_ERR_I),
   .ACT_SHORT_I                (ACT_SHORT_I),
   .ACT_WARN_I                 (ACT_WARN_I),
   .IOL_SHORT_I                (IOL_SHORT_I),
   .DIAG_EN_O                  (DIAG_EN_O),
   .DIAG_SW_O                  (DIAG_SW_O),
   .COMM_IMG_O                 (COMM_IMG_O),
   .PERR_IMG_O                 (PERR_IMG_O),
   .SSHORT_IMG_O               (SSHORT_IMG_O),
   .PDV_IMG_O                  (PDV_IMG_O),
   .STATION_DIAG_O             (STATION_DIAG_O)
);
